// ===== inc/tps_consts.svh
`ifndef TPS_CONSTS_SVH
`define TPS_CONSTS_SVH

// ---------------------------------------------------------------
// Sizes
// ---------------------------------------------------------------
`define TPS_DW 32
`define TPS_NCH 8
`define TPS_NIRQ 16
`define TPS_NALT 3
`define TPS_SEL_W 2
`define TPS_CH_PER_REG 4
`define TPS_CH_STRIDE 8

// ---------------------------------------------------------------
// Field layout inside one channel byte
// ---------------------------------------------------------------
`define TPS_AIN_LSB 0
`define TPS_AOUT_LSB 2
`define TPS_BIN_LSB 4
`define TPS_B0_MSB 6

// ---------------------------------------------------------------
// Select codes and pin one-hots
// ---------------------------------------------------------------
`define TPS_SEL_00 2'h0
`define TPS_SEL_01 2'h1
`define TPS_SEL_10 2'h2
`define TPS_SEL_11 2'h3
`define TPS_B0_SUB_CLOCK_OUTPUT 3'h6
`define TPS_B0_TRIM 3'h7
`define TPS_OH_NONE 3'h0
`define TPS_OH_PIN0 3'h1
`define TPS_OH_PIN1 3'h2
`define TPS_OH_PIN2 3'h4

// ---------------------------------------------------------------
// Device registers: writable masks and reset
// ---------------------------------------------------------------
`define TPS_CH03_WMASK 32'h3F3C_3F7C
`define TPS_CH47_WMASK 32'h3F3C_3F3C
`define TPS_IRQ_WMASK 32'hFFFF_FFFF
`define TPS_REG_RESET 32'h0000_0000

// ---------------------------------------------------------------
// Controller APB map
// ---------------------------------------------------------------
`define TPS_AW 8
`define TPS_OFF_CMD 8'h00
`define TPS_OFF_WDATA 8'h04
`define TPS_OFF_RDATA 8'h08
`define TPS_OFF_STATUS 8'h0C
`define TPS_OFF_PINCFG 8'h10
`define TPS_CMD_GO 0
`define TPS_CMD_WR 1
`define TPS_CMD_SEL_LSB 4
`define TPS_ST_BUSY 0
`define TPS_ST_DONE 1
`define TPS_PC_EN 0

`endif

// ===== inc/tps_pkg.sv
package tps_pkg;

  typedef enum logic [1:0] {
    TPS_REG_CH03 = 2'h0,
    TPS_REG_CH47 = 2'h1,
    TPS_REG_IRQ = 2'h2,
    TPS_REG_NONE = 2'h3
  } tps_reg_t;

  typedef enum logic [1:0] {
    TPS_CTL_IDLE = 2'b01,
    TPS_CTL_WAIT = 2'b10
  } tps_ctl_state_t;

endpackage

// ===== inc/tps_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tps_if;
  import tps_pkg::*;
  logic req;
  logic we;
  tps_reg_t sel;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic ack;

  modport dev (input req, input we, input sel, input wdata, output rdata, output ack);
  modport ctl (output req, output we, output sel, output wdata, input rdata, input ack);
endinterface
`default_nettype wire

// ===== core/tps_alt_sel.sv
`timescale 1ns/1ps
`default_nettype none
`include "tps_consts.svh"
module tps_alt_sel (
  // Select field
  input wire logic [`TPS_SEL_W-1:0] code,
  input wire logic out_mode,
  // Chosen alternative pin
  output logic [`TPS_NALT-1:0] onehot
);
  import tps_pkg::*;

  // Output fields use code 00 as off; input fields treat 00 like 01
  always_comb begin
    case (code)
      `TPS_SEL_00: onehot = out_mode ? `TPS_OH_NONE : `TPS_OH_PIN0;
      `TPS_SEL_01: onehot = `TPS_OH_PIN0;
      `TPS_SEL_10: onehot = `TPS_OH_PIN1;
      `TPS_SEL_11: onehot = `TPS_OH_PIN2;
      default: onehot = `TPS_OH_NONE;
    endcase
  end
endmodule
`default_nettype wire

// ===== core/tps_dev.sv
// Implementation choices: the register select codes and the req/ack register port.
`timescale 1ns/1ps
`default_nettype none
`include "tps_consts.svh"
module tps_dev #(
  parameter bit SUB_CLOCK_OUTPUT_EN = 1'b1,
  parameter bit TRIM_EN = 1'b1
) (
  // Clock and resets
  input wire logic pclk,
  input wire logic presetn,
  input wire logic deep_standby_rst_n,
  // Register port
  tps_if.dev regs,
  // Timer channel side
  input wire logic [`TPS_NCH-1:0] timer_a_out,
  output logic [`TPS_NCH-1:0] timer_a_in,
  output logic [`TPS_NCH-1:0] timer_b_in,
  input wire logic sub_clock_output,
  input wire logic hs_cr_trim_clk,
  // Timer pins, three alternatives per channel
  input wire logic [`TPS_NCH*`TPS_NALT-1:0] a_pin_in,
  output logic [`TPS_NCH*`TPS_NALT-1:0] a_pin_out,
  output logic [`TPS_NCH*`TPS_NALT-1:0] a_pin_oe,
  input wire logic [`TPS_NCH*`TPS_NALT-1:0] b_pin_in,
  // Interrupt pins and channel inputs
  input wire logic [`TPS_NIRQ*`TPS_NALT-1:0] irq_pin_in,
  output logic [`TPS_NIRQ-1:0] irq_in
);
  import tps_pkg::*;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic pick(input logic [`TPS_NALT-1:0] pins,
                                input logic [`TPS_NALT-1:0] oh);
    pick = |(pins & oh);
  endfunction

  function automatic logic [31:0] wmask(input tps_reg_t sel);
    case (sel)
      TPS_REG_CH03: wmask = `TPS_CH03_WMASK;
      TPS_REG_CH47: wmask = `TPS_CH47_WMASK;
      TPS_REG_IRQ: wmask = `TPS_IRQ_WMASK;
      default: wmask = `TPS_REG_RESET;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Select registers
  // ---------------------------------------------------------------
  logic [31:0] ch03_r;
  logic [31:0] ch47_r;
  logic [31:0] irq_r;
  logic [31:0] rdata_r;
  logic [31:0] rd_word;
  logic ack_r;
  logic take;

  // One access per request; the ack pulse blocks a second take
  assign take = regs.req & ~ack_r;

  // only presetn clears the selects
  // The deep standby reset is deliberately not wired here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ch03_r <= `TPS_REG_RESET;
      ch47_r <= `TPS_REG_RESET;
      irq_r <= `TPS_REG_RESET;
    end else if (take && regs.we) begin
      case (regs.sel)
        TPS_REG_CH03: ch03_r <= regs.wdata & wmask(TPS_REG_CH03);
        TPS_REG_CH47: ch47_r <= regs.wdata & wmask(TPS_REG_CH47);
        TPS_REG_IRQ: irq_r <= regs.wdata & wmask(TPS_REG_IRQ);
        default: ;
      endcase
    end
  end

  always_comb begin
    case (regs.sel)
      TPS_REG_CH03: rd_word = ch03_r;
      TPS_REG_CH47: rd_word = ch47_r;
      TPS_REG_IRQ: rd_word = irq_r;
      default: rd_word = `TPS_REG_RESET;
    endcase
  end

  // Handshake state may be lost in deep standby, the selects may not
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_r <= 1'b0;
      rdata_r <= `TPS_REG_RESET;
    end else if (!deep_standby_rst_n) begin
      ack_r <= 1'b0;
      rdata_r <= `TPS_REG_RESET;
    end else begin
      ack_r <= take;
      if (take) begin
        rdata_r <= rd_word;
      end
    end
  end

  assign regs.ack = ack_r;
  assign regs.rdata = rdata_r;

  // ---------------------------------------------------------------
  // Timer channel routing
  // ---------------------------------------------------------------
  wire [`TPS_NCH*`TPS_NALT-1:0] a_out_nxt;
  wire [`TPS_NCH*`TPS_NALT-1:0] a_oe_nxt;
  wire [`TPS_NCH-1:0] a_in_nxt;
  wire [`TPS_NCH-1:0] b_in_nxt;
  wire [`TPS_NIRQ-1:0] irq_nxt;

  genvar ch;
  generate
    for (ch = 0; ch < `TPS_NCH; ch++) begin : g_ch
      localparam int BASE = (ch % `TPS_CH_PER_REG) * `TPS_CH_STRIDE;
      wire [31:0] word;
      wire [`TPS_NALT-1:0] out_oh;
      wire [`TPS_NALT-1:0] in_oh;
      wire [`TPS_NALT-1:0] b_oh;

      // channels 4-7 use the same layout in the second word
      assign word = (ch < `TPS_CH_PER_REG) ? ch03_r : ch47_r;

      // code 00 leaves every pin undriven
      tps_alt_sel u_aout (
        .code(word[BASE+`TPS_AOUT_LSB +: `TPS_SEL_W]),
        .out_mode(1'b1),
        .onehot(out_oh)
      );

      tps_alt_sel u_ain (
        .code(word[BASE+`TPS_AIN_LSB +: `TPS_SEL_W]),
        .out_mode(1'b0),
        .onehot(in_oh)
      );

      tps_alt_sel u_bin (
        .code(word[BASE+`TPS_BIN_LSB +: `TPS_SEL_W]),
        .out_mode(1'b0),
        .onehot(b_oh)
      );

      // the A signal drives at most one pin
      assign a_oe_nxt[ch*`TPS_NALT +: `TPS_NALT] = out_oh;
      assign a_out_nxt[ch*`TPS_NALT +: `TPS_NALT] = {`TPS_NALT{timer_a_out[ch]}} & out_oh;

      if (ch % 2 == 1) begin : g_odd
        // an active output select mutes the input path
        // input chosen only while output code is 00
        // pin level includes any shared driver
        assign a_in_nxt[ch] = (out_oh == `TPS_OH_NONE) ?
                              pick(a_pin_in[ch*`TPS_NALT +: `TPS_NALT], in_oh) : 1'b0;
      end else begin : g_even
        // even A has no input path
        assign a_in_nxt[ch] = 1'b0;
      end

      if (ch == 0) begin : g_b0
        wire [2:0] code;
        wire special;
        assign code = word[`TPS_B0_MSB:`TPS_BIN_LSB];
        // sub-clock only on variants with it
        // trim clock only on variants with it
        assign special = (code == `TPS_B0_SUB_CLOCK_OUTPUT && SUB_CLOCK_OUTPUT_EN) ? sub_clock_output :
                         (code == `TPS_B0_TRIM && TRIM_EN) ? hs_cr_trim_clk : 1'b0;
        // low codes behave like a two-bit input select
        assign b_in_nxt[ch] = code[2] ? special :
                              pick(b_pin_in[ch*`TPS_NALT +: `TPS_NALT], b_oh);
      end else begin : g_bn
        assign b_in_nxt[ch] = pick(b_pin_in[ch*`TPS_NALT +: `TPS_NALT], b_oh);
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Interrupt input routing
  // ---------------------------------------------------------------
  genvar ir;
  generate
    for (ir = 0; ir < `TPS_NIRQ; ir++) begin : g_irq
      wire [`TPS_NALT-1:0] oh;
      tps_alt_sel u_sel (
        .code(irq_r[ir*`TPS_SEL_W +: `TPS_SEL_W]),
        .out_mode(1'b0),
        .onehot(oh)
      );
      assign irq_nxt[ir] = pick(irq_pin_in[ir*`TPS_NALT +: `TPS_NALT], oh);
    end
  endgenerate

  // ---------------------------------------------------------------
  // Registered outputs
  // ---------------------------------------------------------------
  // One cycle of latency buys glitch-free pin enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_pin_out <= '0;
      a_pin_oe <= '0;
      timer_a_in <= '0;
      timer_b_in <= '0;
      irq_in <= '0;
    end else begin
      a_pin_out <= a_out_nxt;
      a_pin_oe <= a_oe_nxt;
      timer_a_in <= a_in_nxt;
      timer_b_in <= b_in_nxt;
      irq_in <= irq_nxt;
    end
  end
endmodule
`default_nettype wire

// ===== core/tps_ctl.sv
`timescale 1ns/1ps
`default_nettype none
`include "tps_consts.svh"
module tps_ctl (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`TPS_AW-1:0] paddr,
  input wire logic [`TPS_DW-1:0] pwdata,
  output logic [`TPS_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Device register port
  tps_if.ctl dev,
  // Shared pin configuration
  output logic analog_input_enable,
  output logic peripheral_function_enable,
  output logic shared_periph_out_off
);
  import tps_pkg::*;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] wmask(input tps_reg_t sel);
    case (sel)
      TPS_REG_CH03: wmask = `TPS_CH03_WMASK;
      TPS_REG_CH47: wmask = `TPS_CH47_WMASK;
      TPS_REG_IRQ: wmask = `TPS_IRQ_WMASK;
      default: wmask = `TPS_REG_RESET;
    endcase
  endfunction

  tps_ctl_state_t state_r;
  logic req_r;
  logic we_r;
  tps_reg_t sel_r;
  logic [31:0] dwdata_r;
  logic [31:0] wdata_r;
  logic [31:0] rdata_r;
  logic done_r;
  logic [31:0] rd_mux;
  logic mapped;
  logic setup;
  logic wr_acc;
  logic go;
  logic finish;

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  assign setup = psel & ~penable;
  assign wr_acc = psel & penable & pready & pwrite & ~pslverr;
  assign go = wr_acc && paddr == `TPS_OFF_CMD && pwdata[`TPS_CMD_GO] &&
              state_r == TPS_CTL_IDLE;
  assign finish = state_r == TPS_CTL_WAIT && dev.ack;

  always_comb begin
    mapped = 1'b1;
    rd_mux = `TPS_REG_RESET;
    case (paddr)
      `TPS_OFF_CMD: begin
        rd_mux[`TPS_CMD_WR] = we_r;
        rd_mux[`TPS_CMD_SEL_LSB +: `TPS_SEL_W] = sel_r;
      end
      `TPS_OFF_WDATA: rd_mux = wdata_r;
      `TPS_OFF_RDATA: rd_mux = rdata_r;
      `TPS_OFF_STATUS: begin
        rd_mux[`TPS_ST_BUSY] = state_r == TPS_CTL_WAIT;
        rd_mux[`TPS_ST_DONE] = done_r;
      end
      `TPS_OFF_PINCFG: rd_mux[`TPS_PC_EN] = peripheral_function_enable;
      default: mapped = 1'b0;
    endcase
  end

  // Fixed single access cycle keeps prdata a plain flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= `TPS_REG_RESET;
    end else begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      prdata <= (setup & ~pwrite) ? rd_mux : `TPS_REG_RESET;
    end
  end

  // ---------------------------------------------------------------
  // Software registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdata_r <= `TPS_REG_RESET;
      we_r <= 1'b0;
      sel_r <= TPS_REG_CH03;
    end else if (wr_acc && paddr == `TPS_OFF_WDATA) begin
      wdata_r <= pwdata;
    end else if (wr_acc && paddr == `TPS_OFF_CMD && state_r == TPS_CTL_IDLE) begin
      we_r <= pwdata[`TPS_CMD_WR];
      sel_r <= tps_reg_t'(pwdata[`TPS_CMD_SEL_LSB +: `TPS_SEL_W]);
    end
  end

  // selected pins: analog off, peripheral function on
  // other functions on shared pins are told to stop driving
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_input_enable <= 1'b1;
      peripheral_function_enable <= 1'b0;
      shared_periph_out_off <= 1'b0;
    end else if (wr_acc && paddr == `TPS_OFF_PINCFG) begin
      analog_input_enable <= ~pwdata[`TPS_PC_EN];
      peripheral_function_enable <= pwdata[`TPS_PC_EN];
      shared_periph_out_off <= pwdata[`TPS_PC_EN];
    end
  end

  // Completion flag: a finishing transfer beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_r <= 1'b0;
    end else if (finish) begin
      done_r <= 1'b1;
    end else if (wr_acc && paddr == `TPS_OFF_STATUS && pwdata[`TPS_ST_DONE]) begin
      done_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Device transfer sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= TPS_CTL_IDLE;
      req_r <= 1'b0;
      dwdata_r <= `TPS_REG_RESET;
      rdata_r <= `TPS_REG_RESET;
    end else begin
      case (state_r)
        TPS_CTL_IDLE: begin
          if (go) begin
            state_r <= TPS_CTL_WAIT;
            req_r <= 1'b1;
            dwdata_r <= wdata_r & wmask(tps_reg_t'(pwdata[`TPS_CMD_SEL_LSB +: `TPS_SEL_W]));
          end
        end
        TPS_CTL_WAIT: begin
          if (dev.ack) begin
            state_r <= TPS_CTL_IDLE;
            req_r <= 1'b0;
            rdata_r <= dev.rdata;
          end
        end
        default: begin
          state_r <= TPS_CTL_IDLE;
          req_r <= 1'b0;
        end
      endcase
    end
  end

  assign dev.req = req_r;
  assign dev.we = we_r;
  assign dev.sel = sel_r;
  assign dev.wdata = dwdata_r;
endmodule
`default_nettype wire

// ===== verif/tps_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "tps_consts.svh"
module tps_chk_sva (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Device register port
  input wire logic req,
  input wire logic we,
  input wire tps_pkg::tps_reg_t sel,
  input wire logic [31:0] wdata,
  input wire logic [31:0] rdata,
  input wire logic ack
);
  import tps_pkg::*;

  // ------
  // Handshake and readback
  // ------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_take_acked: assert property (req && !ack |=> ack)
    else $error("device access not acked one cycle after take");
  a_ack_pulse: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (ack |-> $past(req) && !$past(ack))
    else $error("ack without a pending take");
  a_req_held: assert property (req && !ack |=> req && $stable(sel) && $stable(we) && $stable(wdata))
    else $error("request changed before ack");
  a_req_release: assert property (ack |=> !req)
    else $error("request not dropped after ack");
  a_wr_rsvd_clear: assert property (req && we && sel == TPS_REG_CH47 |->
    (wdata & ~`TPS_CH47_WMASK) == 32'h0000_0000)
    else $error("reserved bits set in write data");
  a_rd_ch03_rsvd: assert property (ack && sel == TPS_REG_CH03 |->
    (rdata & ~`TPS_CH03_WMASK) == 32'h0000_0000)
    else $error("reserved bits read back nonzero");
  a_rd_ch47_rsvd: assert property (ack && sel == TPS_REG_CH47 |->
    (rdata & ~`TPS_CH47_WMASK) == 32'h0000_0000)
    else $error("reserved bits read back nonzero");
  a_none_reads_zero: assert property (ack && sel == TPS_REG_NONE |-> rdata == 32'h0000_0000)
    else $error("unmapped device select returned data");
endmodule
`default_nettype wire

// ===== verif/tb_timer_and_irq_pin_select.sv
`timescale 1ns/1ps
`default_nettype none
`include "tps_consts.svh"
module tb_timer_and_irq_pin_select;
  import tps_pkg::*;

  // ------
  // Signals and instances
  // ------
  logic pclk, presetn, deep_standby_rst_n;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rq;
  logic rerr, aie, pfe, spo, sub_clock_output, hs_cr_trim_clk;
  logic [7:0] timer_a_out, timer_a_in, timer_b_in;
  logic [23:0] a_pin_in, a_pin_out, a_pin_oe, b_pin_in;
  logic [47:0] irq_pin_in;
  logic [15:0] irq_in;
  int errors, check_count, cycles;

  tps_if u_tps_if ();
  tps_ctl u_tps_ctl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dev(u_tps_if.ctl), .analog_input_enable(aie),
    .peripheral_function_enable(pfe), .shared_periph_out_off(spo));
  tps_dev u_tps_dev (.pclk(pclk), .presetn(presetn), .deep_standby_rst_n(deep_standby_rst_n),
    .regs(u_tps_if.dev), .timer_a_out(timer_a_out), .timer_a_in(timer_a_in),
    .timer_b_in(timer_b_in), .sub_clock_output(sub_clock_output),
    .hs_cr_trim_clk(hs_cr_trim_clk), .a_pin_in(a_pin_in), .a_pin_out(a_pin_out),
    .a_pin_oe(a_pin_oe), .b_pin_in(b_pin_in), .irq_pin_in(irq_pin_in), .irq_in(irq_in));
  tps_chk_sva u_tps_chk_sva (.pclk(pclk), .presetn(presetn), .req(u_tps_if.req),
    .we(u_tps_if.we), .sel(u_tps_if.sel), .wdata(u_tps_if.wdata), .rdata(u_tps_if.rdata),
    .ack(u_tps_if.ack));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // ------
  // Helpers
  // ------
  task automatic final_report();
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Ceiling is far above the under one thousand cycles the scenarios need
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      final_report();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rq = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // One device access; rq ends up holding the device's returned word
  task automatic dev(input logic w, input logic [1:0] s, input logic [31:0] d);
    apb(1'b1, `TPS_OFF_WDATA, d);
    apb(1'b1, `TPS_OFF_CMD, {26'h00_0000, s, 2'h0, w, 1'b1});
    do apb(1'b0, `TPS_OFF_STATUS, 32'h0000_0000); while (rq[`TPS_ST_DONE] !== 1'b1);
    apb(1'b1, `TPS_OFF_STATUS, 32'h0000_0002);
    apb(1'b0, `TPS_OFF_RDATA, 32'h0000_0000);
  endtask

  function automatic logic [2:0] alt(input int k);
    return (k == 3) ? 3'h4 : (k == 2) ? 3'h2 : 3'h1;
  endfunction

  // ------
  // Scenarios
  // ------
  task automatic t_reset();
    chk({29'h0000_0000, aie, pfe, spo}, 32'h0000_0004);
    for (int s = 0; s < 3; s++) begin
      dev(1'b0, s[1:0], 32'h0000_0000);
      chk(rq, 32'h0000_0000);
    end
  endtask

  task automatic t_mask();
    logic [31:0] m [3];
    m = '{32'h3F3C_3F7C, 32'h3F3C_3F3C, 32'hFFFF_FFFF};
    for (int s = 0; s < 3; s++) begin
      dev(1'b1, s[1:0], 32'hFFFF_FFFF);
      dev(1'b1, s[1:0], 32'h0000_0000);
      chk(rq, m[s]);
    end
    dev(1'b1, 2'h3, 32'hFFFF_FFFF);
    chk(rq, 32'h0000_0000);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk({31'h0000_0000, rerr}, 32'h0000_0001);
  endtask

  // B selects = k, A output = k, odd A input = 3-k; every pin pattern then inverted
  task automatic t_route();
    logic [23:0] oe_exp, out_exp;
    for (int k = 0; k < 4; k++) begin
      dev(1'b1, 2'h0, {4{2'h0, k[1:0], k[1:0], ~k[1:0]}});
      dev(1'b1, 2'h1, {4{2'h0, k[1:0], k[1:0], ~k[1:0]}});
      dev(1'b1, 2'h2, {16{k[1:0]}});
      oe_exp = (k == 0) ? 24'h00_0000 : {8{alt(k)}};
      for (int c = 0; c < 8; c++)
        out_exp[c*3 +: 3] = oe_exp[c*3 +: 3] & {3{timer_a_out[c]}};
      for (int p = 0; p < 2; p++) begin
        @(posedge pclk);
        b_pin_in <= {8{alt(k) ^ {3{p[0]}}}};
        a_pin_in <= {8{alt(3 - k) ^ {3{p[0]}}}};
        irq_pin_in <= {16{alt(k) ^ {3{p[0]}}}};
        tick(2);
        chk({8'h00, a_pin_oe}, {8'h00, oe_exp});
        chk({8'h00, a_pin_out & a_pin_oe}, {8'h00, out_exp});
        chk({24'h00_0000, timer_b_in}, p ? 32'h0000_0000 : 32'h0000_00FF);
        chk({24'h00_0000, timer_a_in}, (k == 0 && p == 0) ? 32'h0000_00AA : 32'h0000_0000);
        chk({16'h0000, irq_in}, p ? 32'h0000_0000 : 32'h0000_FFFF);
      end
    end
  endtask

  task automatic t_b0();
    logic [2:0] pins;
    logic e;
    for (int c = 0; c < 8; c++) begin
      dev(1'b1, 2'h0, {25'h000_0000, c[2:0], 4'h0});
      for (int q = 0; q < 5; q++) begin
        pins = (q < 3) ? 3'(1 << q) : 3'h0;
        case (c)
          0, 1: e = pins[0];
          2: e = pins[1];
          3: e = pins[2];
          6: e = (q == 3);
          7: e = (q == 4);
          default: e = 1'b0;
        endcase
        @(posedge pclk);
        b_pin_in <= {21'h00_0000, pins};
        sub_clock_output <= (q == 3);
        hs_cr_trim_clk <= (q == 4);
        tick(2);
        chk({31'h0000_0000, timer_b_in[0]}, {31'h0000_0000, e});
      end
    end
  endtask

  task automatic t_keep();
    dev(1'b1, 2'h1, 32'h1234_5678);
    @(posedge pclk);
    deep_standby_rst_n <= 1'b0;
    tick(3);
    deep_standby_rst_n <= 1'b1;
    dev(1'b0, 2'h1, 32'h0000_0000);
    chk(rq, 32'h1234_1638);
    apb(1'b1, `TPS_OFF_PINCFG, 32'h0000_0001);
    // Pin config flops update at the edge that ends the access
    tick(1);
    chk({29'h0000_0000, aie, pfe, spo}, 32'h0000_0003);
    @(posedge pclk);
    presetn <= 1'b0;
    tick(3);
    presetn <= 1'b1;
    dev(1'b0, 2'h1, 32'h0000_0000);
    chk(rq, 32'h0000_0000);
    chk({29'h0000_0000, aie, pfe, spo}, 32'h0000_0004);
  endtask

  initial begin
    {psel, penable, pwrite, paddr, pwdata, sub_clock_output, hs_cr_trim_clk} = '0;
    {a_pin_in, b_pin_in, irq_pin_in} = '0;
    timer_a_out = 8'hA5;
    deep_standby_rst_n = 1'b1;
    presetn = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_mask();
    t_route();
    t_b0();
    t_keep();
    final_report();
  end
endmodule
`default_nettype wire
